// file: core/fpio_port.sv
// four pin general purpose i/o port with direction, option and trim registers
// Behaviour
// (R1) port reads return sampled pin levels, never the output latches
// (R2) every reset sets all direction bits, all pins inputs
// (R3) port data bits 7 to 4 read as zero
// (R4) pin 3 is input only, never driven
// (R5) pull-ups and pin wake on pins 0, 1, 3 under one common control
// (R6) pin 3 as master clear: pull-up always on, no wake
// (R7) direction load copies working register; direction is write only
// (R8) direction one floats the pin; zero drives the output latch
// (R9) pin priority: clock out, comparator, timer input, direction
// (R10) output latches hold until rewritten; inputs sampled at read
// (R11) pins 0 to 2 each have an independent direction bit
// (R12) trim bit 0 set puts divided oscillator on pin 2
// (R13) status bit 7 set after pin wake reset, else cleared
// (R14) status bit 6 set after comparator wake reset, else cleared
// (R15) option bit 7 low enables wake, bit 6 low enables pull-ups
// (R16) direction zero disables pull-up and wake for pins 0 and 1; pin 3 ignores its direction bit
// (R17) timer source select one gives pin 2 to timer input
// (R18) writes to port data bits 7 to 4 have no effect
`timescale 1ns/1ps
`include "fpio_params.svh"
module fpio_port #(
  parameter int DATA_W = 8
) (
  input  wire logic              clk_sys,        // instruction cycle clock
  input  wire logic              resetn,         // async reset, low active
  input  wire logic [7:0]        file_addr,      // file register address
  input  wire logic              file_wr,        // file register write
  input  wire logic              file_rd,        // file register read
  input  wire logic [DATA_W-1:0] file_wdata,     // write data
  output logic      [DATA_W-1:0] file_rdata,     // read data, next cycle
  input  wire logic [DATA_W-1:0] w_reg,          // working register
  input  wire logic              dir_load,       // direction load instruction
  input  wire logic              option_load,    // option load instruction
  input  wire logic              trim_wr,        // trim register write
  output logic      [DATA_W-1:0] trim_value,     // trim register readback
  input  wire logic [3:0]        pin_in,         // pin levels
  output logic      [3:0]        pin_out,        // pin output levels
  output logic      [3:0]        pin_oe,         // pin drivers, high drives
  output logic      [3:0]        pullup_en,      // weak pull-ups
  output logic                   timer_ext_clk,  // pin 2 level for timer
  output logic                   wake_pin_req,   // pin change in sleep
  input  wire logic              sleep,          // core is asleep
  input  wire logic              master_clear_input_cfg,       // pin 3 is master clear
  input  wire logic              cmp_in_en,      // comparator takes pins 0, 1
  input  wire logic              cmp_out_en,     // comparator drives pin 2
  input  wire logic              cmp_out,        // comparator output level
  input  wire logic              int_osc_div4,   // divided oscillator level
  input  wire logic              cause_pin_wake, // reset came from pin wake
  input  wire logic              cause_cmp_wake  // reset came from comparator
);
  // ******************************************************
  // parameter check
  // ******************************************************
  if (DATA_W != 8) begin : g_bad_width
    $error("fpio_port supports only an 8 bit data path");
  end

  // ******************************************************
  // state
  // ******************************************************
  logic [3:0]            dir;
  logic [3:0]            latch;
  logic [3:0]            snap;
  logic [DATA_W-1:0]     option;
  logic                  pin_wake_flag;
  logic                  cmp_wake_flag;
  fpio_pkg::fpio_boot_t  boot;
  logic [2:0]            next_oe;
  logic [2:0]            next_val;
  logic [3:0]            next_pull;
  logic                  next_wake;
  fpio_pkg::fpio_src_t   pin2_src;

  // decode of a file register hit
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ******************************************************
  // direction and option registers
  // ******************************************************
  // write only; loaded by dedicated instructions
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dir <= `FPIO_DIR_RESET;                          // [R2]
    end else if (dir_load) begin
      dir <= w_reg[3:0];                               // [R7] [R11]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      option <= `FPIO_OPT_RESET;
    end else if (option_load) begin
      option <= w_reg;                                 // [R15]
    end
  end

  // ******************************************************
  // output latches and trim register
  // ******************************************************
  // only the low four bits exist; upper write bits are dropped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latch <= 4'h0;
    end else if (file_wr && hit(file_addr, `FPIO_ADDR_PORT)) begin
      latch <= file_wdata[3:0];                        // [R10] [R18]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trim_value <= `FPIO_TRIM_RESET;
    end else if (trim_wr) begin
      trim_value <= w_reg;
    end
  end

  // ******************************************************
  // reset cause flags
  // ******************************************************
  // cause levels are caught on the first edge after release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      boot <= fpio_pkg::FPIO_BOOT_CAPTURE;
    end else begin
      case (boot)
        fpio_pkg::FPIO_BOOT_CAPTURE: boot <= fpio_pkg::FPIO_BOOT_RUN;
        fpio_pkg::FPIO_BOOT_RUN:     boot <= fpio_pkg::FPIO_BOOT_RUN;
        default:                     boot <= fpio_pkg::FPIO_BOOT_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_wake_flag <= 1'b0;
      cmp_wake_flag <= 1'b0;
    end else if (boot == fpio_pkg::FPIO_BOOT_CAPTURE) begin
      pin_wake_flag <= cause_pin_wake;                 // [R13]
      cmp_wake_flag <= cause_cmp_wake;                 // [R14]
    end else if (file_wr && hit(file_addr, `FPIO_ADDR_STATUS)) begin
      pin_wake_flag <= file_wdata[`FPIO_ST_PIN_WAKE];
      cmp_wake_flag <= file_wdata[`FPIO_ST_CMP_WAKE];
    end
  end

  // ******************************************************
  // read path
  // ******************************************************
  // port reads sample the pins themselves, upper bits zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      file_rdata <= '0;
    end else if (file_rd && hit(file_addr, `FPIO_ADDR_PORT)) begin
      file_rdata <= {4'h0, pin_in};                    // [R1] [R3]
    end else if (file_rd && hit(file_addr, `FPIO_ADDR_STATUS)) begin
      file_rdata <= {pin_wake_flag, cmp_wake_flag, 6'h00};
    end else if (file_rd) begin
      file_rdata <= '0;
    end
  end

  // snapshot of the pins at each port read, for change detect
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      snap <= 4'h0;
    end else if (file_rd && hit(file_addr, `FPIO_ADDR_PORT)) begin
      snap <= pin_in;                                  // [R10]
    end
  end

  // ******************************************************
  // pin drivers
  // ******************************************************
  // pins 0 and 1 answer to the comparator inputs, pin 2 to all others
  for (genvar i = 0; i < 3; i++) begin : g_drive
    fpio_pin_drive #(.HAS_ALT(i == 2)) u_drive (
      .dir_bit     (dir[i]),
      .latch_bit   (latch[i]),
      .cmp_in_sel  (cmp_in_en),
      .clk_out_sel (trim_value[`FPIO_TRIM_CLKOUT]),
      .cmp_out_sel (cmp_out_en),
      .timer_sel   (option[`FPIO_OPT_TMR_SRC]),
      .clk_div     (int_osc_div4),
      .cmp_val     (cmp_out),
      .src         (),
      .drv_oe      (next_oe[i]),
      .drv_val     (next_val[i])
    );                                                 // [R8] [R9]
  end

  // pin 2 owner, read only by the checks below
  always_comb begin
    if (trim_value[`FPIO_TRIM_CLKOUT]) begin
      pin2_src = fpio_pkg::FPIO_SRC_CLK_OUT;           // [R12]
    end else if (cmp_out_en) begin
      pin2_src = fpio_pkg::FPIO_SRC_CMP_OUT;
    end else if (option[`FPIO_OPT_TMR_SRC]) begin
      pin2_src = fpio_pkg::FPIO_SRC_TIMER_IN;          // [R17]
    end else begin
      pin2_src = fpio_pkg::FPIO_SRC_DIR;
    end
  end

  // pin 3 has no driver at all
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_oe  <= 4'h0;
      pin_out <= 4'h0;
    end else begin
      pin_oe  <= {1'b0, next_oe};                      // [R4]
      pin_out <= {1'b0, next_val};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timer_ext_clk <= 1'b0;
    end else begin
      timer_ext_clk <= pin_in[2];
    end
  end

  // ******************************************************
  // pull-ups and wake on change
  // ******************************************************
  fpio_wake u_wake (
    .pin_in   (pin_in),
    .snap     (snap),
    .dir      (dir),
    .wake_n   (option[`FPIO_OPT_WAKE_N]),
    .pullup_n (option[`FPIO_OPT_PULLUP_N]),
    .master_clear_input_cfg (master_clear_input_cfg),
    .pull_en  (next_pull),
    .changed  (next_wake)
  );                                                   // [R5] [R6] [R16]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pullup_en    <= 4'h0;
      wake_pin_req <= 1'b0;
    end else begin
      pullup_en    <= next_pull;                       // [R5]
      wake_pin_req <= sleep & next_wake;               // [R15]
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  read_pins_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R1]
    file_rd && file_addr == `FPIO_ADDR_PORT |=> file_rdata == {4'h0, $past(pin_in)})
    else $error("port read did not return pin levels");

  upper_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R3]
    $past(file_rd) && $past(file_addr) == `FPIO_ADDR_PORT |-> file_rdata[7:4] == 4'h0)
    else $error("upper port bits not zero");

  reset_float_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
    boot == fpio_pkg::FPIO_BOOT_CAPTURE |-> pin_oe == 4'h0 && dir == `FPIO_DIR_RESET)
    else $error("pins driven right after reset");

  pin3_float_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R4]
    !pin_oe[3])
    else $error("pin 3 driven");

  dir_load_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R7]
    dir_load |=> dir == $past(w_reg[3:0]))
    else $error("direction load lost");

  drive_latch_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R8]
    !dir_load && !cmp_in_en && !dir[0] ##1 !dir[0] |-> pin_oe[0] && pin_out[0] == $past(latch[0]))
    else $error("pin 0 not driving its latch");

  latch_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
    !(file_wr && file_addr == `FPIO_ADDR_PORT) |=> $stable(latch))
    else $error("latch changed without a write");

  clk_out_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
    trim_value[0] |=> pin_oe[2] && pin_out[2] == $past(int_osc_div4))
    else $error("clock output not on pin 2");

  timer_take_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R17]
    pin2_src == fpio_pkg::FPIO_SRC_TIMER_IN |=> !pin_oe[2])
    else $error("pin 2 driven while timer owns it");

  master_clear_input_pull_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R6]
    master_clear_input_cfg |=> pullup_en[3])
    else $error("master clear pull-up off");

  pull_group_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R16]
    !pullup_en[2] && (!pullup_en[1] || ($past(dir[1]) && !$past(option[6]))))
    else $error("pull-up enable wrong");

  wake_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R15]
    wake_pin_req |-> $past(sleep) && !$past(option[7]))
    else $error("wake request while disabled");

  cause_flags_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R13] [R14]
    boot == fpio_pkg::FPIO_BOOT_CAPTURE |=>
      pin_wake_flag == $past(cause_pin_wake) && cmp_wake_flag == $past(cause_cmp_wake))
    else $error("reset cause flags wrong");
endmodule

// file: core/fpio_params.svh
// constants of the four pin i/o port: offsets, fields, reset values
`ifndef FPIO_PARAMS_SVH
`define FPIO_PARAMS_SVH
`define FPIO_ADDR_STATUS   8'h03
`define FPIO_ADDR_PORT     8'h06
`define FPIO_DIR_RESET     4'hF
`define FPIO_OPT_RESET     8'hFF
`define FPIO_TRIM_RESET    8'hFE
`define FPIO_OPT_WAKE_N    7
`define FPIO_OPT_PULLUP_N  6
`define FPIO_OPT_TMR_SRC   5
`define FPIO_ST_PIN_WAKE   7
`define FPIO_ST_CMP_WAKE   6
`define FPIO_TRIM_CLKOUT   0
`endif

// file: core/fpio_pkg.sv
// types shared by the four pin i/o port
package fpio_pkg;
  // which function owns pin 2
  typedef enum logic [1:0] {
    FPIO_SRC_DIR,
    FPIO_SRC_TIMER_IN,
    FPIO_SRC_CMP_OUT,
    FPIO_SRC_CLK_OUT
  } fpio_src_t;
  // reset-cause capture sequence
  typedef enum logic {
    FPIO_BOOT_CAPTURE,
    FPIO_BOOT_RUN
  } fpio_boot_t;
endpackage

// file: core/fpio_pin_drive.sv
// output driver selection for one bidirectional pin
`timescale 1ns/1ps
module fpio_pin_drive #(
  parameter bit HAS_ALT = 1'b0
) (
  input  wire logic                dir_bit,      // 1 = high impedance
  input  wire logic                latch_bit,    // output latch value
  input  wire logic                cmp_in_sel,   // comparator input owns pin
  input  wire logic                clk_out_sel,  // divided clock owns pin
  input  wire logic                cmp_out_sel,  // comparator output owns pin
  input  wire logic                timer_sel,    // timer clock input owns pin
  input  wire logic                clk_div,      // divided oscillator level
  input  wire logic                cmp_val,      // comparator output level
  output fpio_pkg::fpio_src_t      src,          // owning function
  output logic                     drv_oe,       // driver enable
  output logic                     drv_val       // driven level
);
  // fixed priority: clock out, comparator out, timer in, direction
  always_comb begin
    src = fpio_pkg::FPIO_SRC_DIR;
    drv_oe = ~dir_bit;
    drv_val = latch_bit;
    if (HAS_ALT && clk_out_sel) begin
      src = fpio_pkg::FPIO_SRC_CLK_OUT;
      drv_oe = 1'b1;
      drv_val = clk_div;
    end else if (HAS_ALT && cmp_out_sel) begin
      src = fpio_pkg::FPIO_SRC_CMP_OUT;
      drv_oe = 1'b1;
      drv_val = cmp_val;
    end else if (HAS_ALT && timer_sel) begin
      src = fpio_pkg::FPIO_SRC_TIMER_IN;
      drv_oe = 1'b0;
    end else if (!HAS_ALT && cmp_in_sel) begin
      drv_oe = 1'b0;
    end
  end
endmodule

// file: core/fpio_wake.sv
// shared pull-up and wake-on-change enables for pins 0, 1 and 3
`timescale 1ns/1ps
module fpio_wake (
  input  wire logic [3:0] pin_in,     // pin levels
  input  wire logic [3:0] snap,       // levels at the last port read
  input  wire logic [3:0] dir,        // direction bits
  input  wire logic       wake_n,     // common wake enable, low active
  input  wire logic       pullup_n,   // common pull-up enable, low active
  input  wire logic       master_clear_input_cfg,   // pin 3 is master clear
  output logic      [3:0] pull_en,    // weak pull-up per pin
  output logic            changed     // enabled pin differs from snapshot
);
  logic [3:0] wake_en;
  // one control for all three pins; a driven pin loses both functions
  always_comb begin
    pull_en = 4'h0;
    wake_en = 4'h0;
    pull_en[0] = ~pullup_n & dir[0];
    pull_en[1] = ~pullup_n & dir[1];
    pull_en[3] = ~pullup_n | master_clear_input_cfg;
    wake_en[0] = ~wake_n & dir[0];
    wake_en[1] = ~wake_n & dir[1];
    wake_en[3] = ~wake_n & ~master_clear_input_cfg;
    changed = |(wake_en & (pin_in ^ snap));
  end
endmodule

// file: bench/fpio_pin_env.sv
// external circuitry model on the four port pins
`timescale 1ns/1ps
module fpio_pin_env (
  input  wire logic       clk_sys,    // instruction clock
  input  wire logic [3:0] pin_out,    // device output levels
  input  wire logic [3:0] pin_oe,     // device drivers, high drives
  input  wire logic [3:0] pullup_en,  // device weak pull-ups
  input  wire logic [3:0] ext_en,     // external driver enables
  input  wire logic [3:0] ext_val,    // external driven levels
  output logic      [3:0] pin_in      // resolved pin levels
);
  logic flt = 1'b0;
  // an undriven pin wanders each cycle so a stale level never passes
  always @(posedge clk_sys) begin
    flt <= ~flt;
  end
  // a strong external driver beats the device driver, then pull-up, then float
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = ext_en[i] ? ext_val[i] : pin_oe[i] ? pin_out[i] : pullup_en[i] ? 1'b1 : flt;
    end
  end
endmodule

// file: bench/fpio_port_bench.sv
// self-checking bench for the four pin i/o port
`timescale 1ns/1ps
`include "fpio_params.svh"
module fpio_port_bench;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] file_addr = 8'h00;
  logic [7:0] file_wdata = 8'h00;
  logic [7:0] w_reg = 8'h00;
  logic       file_wr = 1'b0, file_rd = 1'b0, dir_load = 1'b0, option_load = 1'b0, trim_wr = 1'b0;
  logic       sleep = 1'b0, master_clear_input_cfg = 1'b0, cmp_in_en = 1'b0, cmp_out_en = 1'b0, cmp_out = 1'b0;
  logic       int_osc_div4 = 1'b0, cause_pin_wake = 1'b0, cause_cmp_wake = 1'b0;
  logic [3:0] ext_en = 4'h0;
  logic [3:0] ext_val = 4'h0;
  logic [7:0] file_rdata, trim_value;
  logic [3:0] pin_in, pin_out, pin_oe, pullup_en;
  logic       timer_ext_clk, wake_pin_req;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  wire  [7:0] pin2_st = {6'h00, pin_oe[2], pin_out[2]};

  fpio_port i_dut (.clk_sys, .resetn, .file_addr, .file_wr, .file_rd, .file_wdata, .file_rdata, .w_reg,
    .dir_load, .option_load, .trim_wr, .trim_value, .pin_in, .pin_out, .pin_oe, .pullup_en, .timer_ext_clk,
    .wake_pin_req, .sleep, .master_clear_input_cfg, .cmp_in_en, .cmp_out_en, .cmp_out, .int_osc_div4, .cause_pin_wake,
    .cause_cmp_wake);
  fpio_pin_env i_pins (.clk_sys, .pin_out, .pin_oe, .pullup_en, .ext_en, .ext_val, .pin_in);

  // 10 MHz clock and hang guard
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // instruction load: 0 direction, 1 option, 2 trim; outputs settle two edges on
  task automatic ld(input logic [1:0] k, input logic [7:0] v);
    w_reg = v;
    dir_load = (k == 2'h0);
    option_load = (k == 2'h1);
    trim_wr = (k == 2'h2);
    cyc(1);
    dir_load = 1'b0;
    option_load = 1'b0;
    trim_wr = 1'b0;
    cyc(2);
  endtask
  task automatic fwr(input logic [7:0] a, input logic [7:0] d);
    file_addr = a;
    file_wdata = d;
    file_wr = 1'b1;
    cyc(1);
    file_wr = 1'b0;
    cyc(1);
  endtask
  task automatic frd(input logic [7:0] a, input logic [7:0] exp);
    file_addr = a;
    file_rd = 1'b1;
    cyc(1);
    file_rd = 1'b0;
    cyc(1);
    chk(file_rdata, exp);
  endtask
  task automatic do_reset(input int n);
    resetn = 1'b0;
    cyc(n);
    resetn = 1'b1;
    cyc(2);
    cause_pin_wake = 1'b0;
    cause_cmp_wake = 1'b0;
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk({4'h0, pin_oe}, 8'h00);
    chk(trim_value, 8'hFE);
    chk({4'h0, pullup_en}, 8'h00);
    frd(`FPIO_ADDR_STATUS, 8'h00);
  endtask
  task automatic t_dir();
    ext_en = 4'h8;
    ext_val = 4'h8;
    ld(2'h1, 8'hDF);
    fwr(`FPIO_ADDR_PORT, 8'hF5);
    ld(2'h0, 8'h00);
    chk({4'h0, pin_oe}, 8'h07);
    chk({5'h00, pin_out[2:0]}, 8'h05);
    frd(`FPIO_ADDR_PORT, 8'h0D);
    ext_en = 4'h9;
    frd(`FPIO_ADDR_PORT, 8'h0C);
    ld(2'h0, 8'h05);
    chk({4'h0, pin_oe}, 8'h02);
    frd(8'h07, 8'h00);
    ld(2'h0, 8'hFF);
    chk({4'h0, pin_oe}, 8'h00);
    ld(2'h0, 8'h00);
    chk({5'h00, pin_out[2:0]}, 8'h05);
  endtask
  task automatic t_pin2();
    cmp_out_en = 1'b1;
    cyc(2);
    chk(pin2_st, 8'h02);
    int_osc_div4 = 1'b1;
    ld(2'h2, 8'h01);
    chk(trim_value, 8'h01);
    chk(pin2_st, 8'h03);
    int_osc_div4 = 1'b0;
    cyc(2);
    chk(pin2_st, 8'h02);
    ld(2'h2, 8'hFE);
    cmp_out_en = 1'b0;
    ld(2'h1, 8'hFF);
    chk(pin2_st, 8'h01);
    ext_en = 4'h4;
    ext_val = 4'h4;
    cyc(2);
    chk({7'h00, timer_ext_clk}, 8'h01);
    ext_val = 4'h0;
    cyc(2);
    chk({7'h00, timer_ext_clk}, 8'h00);
    ld(2'h1, 8'hDF);
    chk(pin2_st, 8'h03);
    cmp_in_en = 1'b1;
    cyc(2);
    chk({6'h00, pin_oe[1:0]}, 8'h00);
    cmp_in_en = 1'b0;
  endtask
  task automatic t_wake();
    ld(2'h0, 8'hFF);
    ld(2'h1, 8'h3F);
    chk({4'h0, pullup_en}, 8'h0B);
    sleep = 1'b1;
    frd(`FPIO_ADDR_PORT, 8'h0B);
    ext_val = 4'h4;
    cyc(3);
    chk({7'h00, wake_pin_req}, 8'h00);
    frd(`FPIO_ADDR_PORT, 8'h0F);
    ext_en = 4'h5;
    cyc(3);
    chk({7'h00, wake_pin_req}, 8'h01);
    ext_en = 4'h4;
    master_clear_input_cfg = 1'b1;
    cyc(3);
    ext_en = 4'hC;
    cyc(3);
    chk({7'h00, wake_pin_req}, 8'h00);
    ld(2'h1, 8'hFF);
    chk({4'h0, pullup_en}, 8'h08);
    master_clear_input_cfg = 1'b0;
    ld(2'h1, 8'h3F);
    ld(2'h0, 8'h0E);
    chk({4'h0, pullup_en}, 8'h0A);
    chk({7'h00, wake_pin_req}, 8'h01);
    sleep = 1'b0;
  endtask
  task automatic t_cause();
    cause_pin_wake = 1'b1;
    do_reset(4);
    frd(`FPIO_ADDR_STATUS, 8'h80);
    chk({4'h0, pin_oe}, 8'h00);
    cause_cmp_wake = 1'b1;
    do_reset(4);
    frd(`FPIO_ADDR_STATUS, 8'h40);
    fwr(`FPIO_ADDR_STATUS, 8'h80);
    frd(`FPIO_ADDR_STATUS, 8'h80);
  endtask

  // main sequence
  initial begin
    do_reset(16);
    t_reset();
    t_dir();
    t_pin2();
    t_wake();
    t_cause();
    wrap_up();
  end
endmodule
